//--- logic/smbus_engine_defs.vh
// constants for the smbus byte sequencing engine: register offsets,
// status bit positions, reset values and bit timing.
// assumes it is included by bare name from logic/ design files.
`ifndef SMBUS_ENGINE_DEFS_VH
`define SMBUS_ENGINE_DEFS_VH

// register offsets on the special function register port
`define ADDR_CTRL      8'hc0
`define ADDR_CFG       8'hc1
`define ADDR_DATA      8'hc2

// reset values
`define DATA_RST       8'h00
`define CFG_RST        8'h00
`define ZERO8          8'h00

// serial_control_status bit positions
`define CS_MASTER      7
`define CS_TXMODE      6
`define CS_STA         5
`define CS_STO         4
`define CS_ACK_NEEDED_FLAG       3
`define CS_ARBLOST     2
`define CS_ACK         1
`define CS_SI          0

// configuration bit positions
`define CF_EN          7
`define CF_INH         6

// bit timing: one bit is four quarter phases
`define QUARTER_BIT_NS 2500
`define CLK_PERIOD_NS  20

// byte framing
`define LAST_DATA_BIT  4'h7
`define ACK_SLOT       4'h8

// quarter phase codes
`define PH_DRIVE       2'h0
`define PH_RISE        2'h1
`define PH_SAMPLE      2'h2
`define PH_FALL        2'h3

`endif

//--- logic/bus_line_watch.v
// two-flop synchronisers for the serial clock and data lines, with edge,
// start, stop and bus-busy detection on the system clock.
// assumes scl_i and sda_i are the resolved open-drain wire levels.
`timescale 1ns/1ns
`default_nettype none

module bus_line_watch (
   // clock and reset
   input  wire ref_clk,
   input  wire sys_rst,
   // raw wire levels
   input  wire scl_i,
   input  wire sda_i,
   // synchronised levels and events
   output reg  scl_s,
   output reg  sda_s,
   output wire scl_rise,
   output wire scl_fall,
   output wire start_det,
   output wire stop_det,
   output reg  busy
);

   reg scl_m;   // first stage, read only by scl_s
   reg sda_m;   // first stage, read only by sda_s
   reg scl_d;   // previous synchronised scl
   reg sda_d;   // previous synchronised sda

   // lines idle high, so reset to the released level
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         scl_m <= 1'b1;
         sda_m <= 1'b1;
         scl_s <= 1'b1;
         sda_s <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl_i;
         sda_m <= sda_i;
         scl_s <= scl_m;
         sda_s <= sda_m;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // edges seen only after both stages
   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   // data moving while clock is high marks start or stop
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   // bus owned by someone between a start and a stop
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         busy <= 1'b0;
      end else if (start_det) begin
         busy <= 1'b1;
      end else if (stop_det) begin
         busy <= 1'b0;
      end
   end

endmodule // bus_line_watch

`default_nettype wire

//--- logic/smbus_transfer_mode_engine.v
// byte sequencing engine of a two-wire smbus port: data shift register,
// four transfer modes, per-byte stall and software ack control.
// assumes a cpu register port on ref_clk and open-drain bus pins.
`timescale 1ns/1ns
`default_nettype none
`include "smbus_engine_defs.vh"

// Summary of operation
// - eight-bit data register, read/write, resets zero
// - data held stable while byte event set
// - always exactly one of four modes
// - master from generated start until stop/lost
// - receive interrupts before ack, transmit after
// - master write: start, address, acked bytes
// - stop generated after stop request set
// - unwritten data after master send: receive
// - master read: drive clock, sample slave data
// - ack bit one sends ack, zero nack
// - receiver leaves by stop; write makes sender
// - start plus address: slave receive, flag
// - nacked address silences slave until start
// - slave receive ends at stop; write sends
// - acked read address: load byte, transmit
// - after nack no data write, else error
// - slave send ends at stop; else receive
// - msb first, shift in and out together
// - clearing event flag resumes; set holds clock
module smbus_transfer_mode_engine #(
   parameter QUARTER_CYC = (`QUARTER_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire       ref_clk,
   input  wire       sys_rst,
   // special function register port
   input  wire [7:0] sfr_addr,
   input  wire       sfr_wr,
   input  wire       sfr_rd,
   input  wire [7:0] sfr_wdata,
   output reg  [7:0] sfr_rdata,
   // byte event interrupt
   output reg        byte_event_irq,
   // serial clock pin
   input  wire       scl_i,
   output reg        scl_o,
   output reg        scl_oe,
   // serial data pin
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe
);

   localparam [31:0] QC       = QUARTER_CYC;
   localparam [7:0]  DIV_LAST = QC[7:0] - 8'h01;

   // one-hot sequencer states
   localparam [6:0] ST_IDLE  = 7'h01;
   localparam [6:0] ST_START = 7'h02;
   localparam [6:0] ST_BIT   = 7'h04;
   localparam [6:0] ST_ACK   = 7'h08;
   localparam [6:0] ST_STOP  = 7'h10;
   localparam [6:0] ST_WRX   = 7'h20;   // stalled before ack slot
   localparam [6:0] ST_WTX   = 7'h40;   // stalled after ack slot

   reg  [6:0] state_reg;     // sequencer state
   reg  [7:0] serial_data_byte_reg;  // data / shift register
   reg        master_reg;    // mode: master
   reg        txmode_reg;    // mode: transmitter
   reg        start_request_bit_reg;
   reg        stop_reg;      // stop request / stop seen
   reg        ack_needed_flag_reg;
   reg        arblost_reg;   // lost arbitration or slave error
   reg        ack_reg;       // ack to send / ack received
   reg        enable_reg;    // interface enable
   reg        slave_event_inhibit_reg;
   reg        dat_wr_reg;    // data written during this stall
   reg        addr_ph_reg;   // current byte is the address byte
   reg  [3:0] bit_cnt_reg;   // bits sampled in this frame
   reg  [7:0] div_reg;       // quarter bit divider
   reg  [1:0] ph_reg;        // quarter phase of master bit

   wire scl_s;
   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire busy;

   wire [7:0] status_vec;
   wire       wr_ctrl;
   wire       wr_cfg;
   wire       wr_data;
   wire       stalled;
   wire       tick;
   wire       drv;
   wire       smp;
   wire       resume;

   // line synchronisers and start/stop detection
   bus_line_watch u_watch (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .scl_s     (scl_s),
      .sda_s     (sda_s),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det),
      .busy      (busy)
   );

   // mode bits, requests and flags as software sees them
   assign status_vec = {master_reg, txmode_reg, start_request_bit_reg, stop_reg,
                        ack_needed_flag_reg, arblost_reg, ack_reg, byte_event_irq};

   assign wr_ctrl = sfr_wr & (sfr_addr == `ADDR_CTRL);
   assign wr_cfg  = sfr_wr & (sfr_addr == `ADDR_CFG);
   assign wr_data = sfr_wr & (sfr_addr == `ADDR_DATA);

   assign stalled = (state_reg == ST_WRX) | (state_reg == ST_WTX);
   // master paces bits off the divider; slave follows the far clock
   assign tick = (div_reg == DIV_LAST);
   assign drv  = master_reg ? (tick & (ph_reg == `PH_DRIVE)) : scl_fall;
   assign smp  = master_reg ? (tick & (ph_reg == `PH_SAMPLE) & scl_s) : scl_rise;
   // a stall only ends once software clears the flag with the clock low
   assign resume = ((state_reg == ST_WTX) & ~byte_event_irq & (master_reg | ~scl_s)) |
                   ((state_reg == ST_ACK) & drv & ~ack_needed_flag_reg);

   // quarter bit divider, idle unless a master is moving bits
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         div_reg <= `ZERO8;
      end else if (~master_reg | stalled | tick) begin
         div_reg <= `ZERO8;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // registered read port; unmapped offsets read as zero
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sfr_rdata <= `ZERO8;
      end else if (sfr_rd) begin
         if (sfr_addr == `ADDR_DATA) begin
            sfr_rdata <= serial_data_byte_reg;
         end else if (sfr_addr == `ADDR_CTRL) begin
            sfr_rdata <= status_vec;
         end else if (sfr_addr == `ADDR_CFG) begin
            sfr_rdata <= {enable_reg, slave_event_inhibit_reg, 6'h00};
         end else begin
            sfr_rdata <= `ZERO8;
         end
      end
   end

   // sequencer; hardware updates come last so a set beats a clear
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg               <= ST_IDLE;
         serial_data_byte_reg    <= `DATA_RST;
         master_reg              <= 1'b0;
         txmode_reg              <= 1'b0;
         start_request_bit_reg   <= 1'b0;
         stop_reg                <= 1'b0;
         ack_needed_flag_reg     <= 1'b0;
         arblost_reg             <= 1'b0;
         ack_reg                 <= 1'b0;
         byte_event_irq          <= 1'b0;
         enable_reg              <= 1'b0;
         slave_event_inhibit_reg <= 1'b0;
         dat_wr_reg              <= 1'b0;
         addr_ph_reg             <= 1'b0;
         bit_cnt_reg             <= 4'h0;
         ph_reg                  <= `PH_DRIVE;
         scl_o                   <= 1'b0;
         scl_oe                  <= 1'b0;
         sda_o                   <= 1'b0;
         sda_oe                  <= 1'b0;
      end else begin
         // open drain: only ever pull low
         scl_o <= 1'b0;
         sda_o <= 1'b0;

         // software side of the control and config registers
         if (wr_cfg) begin
            enable_reg              <= sfr_wdata[`CF_EN];
            slave_event_inhibit_reg <= sfr_wdata[`CF_INH];
         end
         if (wr_ctrl) begin
            start_request_bit_reg <= sfr_wdata[`CS_STA];
            stop_reg              <= sfr_wdata[`CS_STO];
            ack_reg               <= sfr_wdata[`CS_ACK];
            byte_event_irq        <= sfr_wdata[`CS_SI];
            if (~sfr_wdata[`CS_SI]) begin
               arblost_reg <= 1'b0;
            end
         end
         // data only accepted while byte_event_irq is set, as it is in every stall until software clears it
         if (wr_data & byte_event_irq) begin
            serial_data_byte_reg <= sfr_wdata;
            dat_wr_reg           <= 1'b1;
            // writing after a received nack as slave sender is an error
            if ((state_reg == ST_WTX) & ~master_reg & txmode_reg & ~ack_reg) begin
               arblost_reg <= 1'b1;
            end
         end

         // master phase walk; phase holds while a slave stretches scl
         if (master_reg & ~stalled & tick & ~((ph_reg == `PH_SAMPLE) & ~scl_s)) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == `PH_RISE) begin
               scl_oe <= 1'b0;
            end else if (ph_reg == `PH_FALL) begin
               scl_oe <= 1'b1;
            end
         end
         // a slave holds scl low through a stall
         if (~master_reg) begin
            scl_oe <= byte_event_irq & ~scl_s & (state_reg != ST_IDLE);
         end

         case (state_reg)
            ST_IDLE: begin
               sda_oe <= 1'b0;
               if (start_request_bit_reg & enable_reg & ~busy & ~byte_event_irq) begin
                  state_reg  <= ST_START;
                  master_reg <= 1'b1;
                  txmode_reg <= 1'b1;
                  ph_reg     <= `PH_DRIVE;
               end
            end
            ST_START: begin
               // release data, raise clock, pull data low, pull clock low
               if (tick & (ph_reg == `PH_DRIVE)) begin
                  sda_oe <= 1'b0;
               end else if (tick & (ph_reg == `PH_SAMPLE) & scl_s) begin
                  sda_oe <= 1'b1;
               end else if (tick & (ph_reg == `PH_FALL)) begin
                  byte_event_irq <= 1'b1;
                  addr_ph_reg    <= 1'b1;
                  state_reg      <= ST_WTX;
                  ph_reg         <= `PH_DRIVE;
               end
            end
            ST_BIT: begin
               // present the msb while clock is low
               if (drv) begin
                  sda_oe <= txmode_reg & (bit_cnt_reg < `ACK_SLOT) &
                            ~serial_data_byte_reg[7];
               end
               if (smp & (bit_cnt_reg < `ACK_SLOT)) begin
                  serial_data_byte_reg <= {serial_data_byte_reg[6:0], sda_s};
                  bit_cnt_reg          <= bit_cnt_reg + 4'h1;
                  if (master_reg & txmode_reg & ~sda_oe & ~sda_s) begin
                     // sent a one, saw a zero: another master won
                     master_reg     <= 1'b0;
                     txmode_reg     <= 1'b0;
                     arblost_reg    <= 1'b1;
                     byte_event_irq <= 1'b1;
                     state_reg      <= ST_IDLE;
                     scl_oe         <= 1'b0;
                  end else if (~txmode_reg & (bit_cnt_reg == `LAST_DATA_BIT)) begin
                     // receiver: interrupt ahead of the ack slot
                     byte_event_irq      <= 1'b1;
                     ack_needed_flag_reg <= 1'b1;
                     state_reg           <= ST_WRX;
                     if (master_reg) begin
                        scl_oe <= 1'b1;
                        ph_reg <= `PH_DRIVE;
                     end
                  end
               end else if (smp) begin
                  // transmitter: take the ack, interrupt after it
                  ack_reg        <= ~sda_s;
                  byte_event_irq <= 1'b1;
                  state_reg      <= ST_WTX;
                  if (master_reg) begin
                     scl_oe <= 1'b1;
                     ph_reg <= `PH_DRIVE;
                  end
               end
            end
            ST_WRX: begin
               if (~byte_event_irq & (master_reg | ~scl_s)) begin
                  sda_oe    <= ack_reg;
                  state_reg <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (smp) begin
                  ack_needed_flag_reg <= 1'b0;
               end
            end
            ST_STOP: begin
               // clock released at the rise phase, then data rises
               if (tick & (ph_reg == `PH_SAMPLE) & scl_s) begin
                  sda_oe     <= 1'b0;
                  master_reg <= 1'b0;
                  txmode_reg <= 1'b0;
                  stop_reg   <= 1'b0;
                  state_reg  <= ST_IDLE;
               end
            end
            default: begin
               // ST_WTX waits for resume
            end
         endcase

         // next event after a stall or an ack slot
         if (resume) begin
            dat_wr_reg  <= 1'b0;
            addr_ph_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (master_reg & stop_reg) begin
               sda_oe    <= 1'b1;
               state_reg <= ST_STOP;
            end else if (master_reg & start_request_bit_reg) begin
               sda_oe    <= 1'b0;
               state_reg <= ST_START;
            end else if (~master_reg & addr_ph_reg & ~ack_reg) begin
               // address refused: silent until the next start
               sda_oe    <= 1'b0;
               state_reg <= ST_IDLE;
            end else begin
               // write during the stall picks the transmitter, else receiver
               txmode_reg <= dat_wr_reg;
               sda_oe     <= dat_wr_reg & ~serial_data_byte_reg[7];
               state_reg  <= ST_BIT;
            end
         end

         // another master addresses us
         if (start_det & ~master_reg & enable_reg & ~slave_event_inhibit_reg) begin
            state_reg   <= ST_BIT;
            txmode_reg  <= 1'b0;
            addr_ph_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b0;
         end else if (stop_det & ~master_reg & (state_reg != ST_IDLE)) begin
            // stop ends either slave mode
            stop_reg       <= 1'b1;
            byte_event_irq <= 1'b1;
            txmode_reg     <= 1'b0;
            sda_oe         <= 1'b0;
            state_reg      <= ST_IDLE;
         end
      end
   end

endmodule // smbus_transfer_mode_engine

`default_nettype wire

//--- tb/engine_sva.sv
// concurrent checks on the byte engine's register port and bus pins.
// assumes it is bound onto smbus_transfer_mode_engine and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module engine_sva (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       byte_event_irq,
   // bus pins
   input wire logic       scl_i,
   input wire logic       scl_o,
   input wire logic       scl_oe,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // reset must leave the port quiet, so this one is not disabled by reset
   reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=>
      sfr_rdata == 8'h00 && !byte_event_irq && !scl_oe && !sda_oe) else $error("port not idle after reset");
   // open drain: the pins only ever pull low
   pins_open_a: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("pin driven high");
   // only software clears the byte event
   flag_sticky_a: assert property (byte_event_irq && !sfr_wr |=> byte_event_irq) else $error("flag dropped");
   // a stall keeps the clock low until software acts
   clock_stall_a: assert property (byte_event_irq && scl_oe && !sfr_wr |=> scl_oe) else $error("clock freed");
   // nothing moves on the data line during a stall
   data_stall_a: assert property (byte_event_irq && !sfr_wr |=> $stable(sda_oe)) else $error("data moved");
   // a start request on an idle bus is answered by a byte event
   start_reply_a: assert property (sfr_wr && sfr_addr == 8'hc0 && sfr_wdata[5] && !sfr_wdata[0]
      && !byte_event_irq && scl_i && sda_i |-> ##[1:1000] byte_event_irq) else $error("no start event");
   // unmapped offsets read as zero
   unmapped_read_a: assert property (sfr_rd && sfr_addr > 8'hc2 |=> sfr_rdata == 8'h00) else $error("unmapped");
   // read data only changes on a read
   rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
endmodule // engine_sva
bind smbus_transfer_mode_engine engine_sva sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .byte_event_irq(byte_event_irq),
   .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

//--- tb/smbus_far_end.sv
// behavioural far-end device: a slave that answers the engine as master,
// and master tasks that address the engine as a slave.
// assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ns
`default_nettype none
module smbus_far_end (
   // resolved wire levels
   input  wire logic scl_w,
   input  wire logic sda_w,
   // pull-down enables
   output var  logic scl_oe,
   output var  logic sda_oe
);
   logic [7:0] rx_last;   // last byte taken as slave
   logic [7:0] tx_byte;   // byte returned on reads
   logic [7:0] sh;        // shift register
   logic       rd_dir;    // we are sending in this frame
   logic       first;     // next byte is the address
   logic       ack_seen;  // master acked our last byte
   logic       slv_on;    // slave answering enabled
   logic       r;         // bit sampled by master tasks
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      slv_on = 1'b1;
      tx_byte = 8'h00;
      ack_seen = 1'b0;
      rx_last = 8'h00;
   end
   // slave frame from a start; a stop cuts it short
   always @(negedge sda_w) if (scl_w === 1'b1 && slv_on) begin : frame
      rd_dir = 1'b0;
      first = 1'b1;
      forever begin
         if (!rd_dir) begin
            repeat (8) begin @(posedge scl_w); sh = {sh[6:0], sda_w}; end // msb first
            rx_last = sh;
            if (first) rd_dir = sh[0]; // direction in the lsb
            first = 1'b0;
            @(negedge scl_w); sda_oe = 1'b1; // every byte acked
            @(negedge scl_w); sda_oe = rd_dir && !tx_byte[7]; // first bit goes out at once
         end else begin
            for (int i = 6; i >= 0; i--) begin @(negedge scl_w); sda_oe = !tx_byte[i]; end
            @(negedge scl_w); sda_oe = 1'b0;
            @(posedge scl_w); ack_seen = !sda_w;
            @(negedge scl_w); sda_oe = ack_seen && !tx_byte[7];
            rd_dir = ack_seen; // a nack ends our sending
         end
      end
   end
   // stop frees the data line
   always @(posedge sda_w) if (scl_w === 1'b1 && slv_on) begin
      disable frame;
      sda_oe = 1'b0;
   end
   // one bit as master; data moves mid-low so no false start is seen
   task automatic m_bit(input logic v);
      #40 sda_oe = !v;
      #40 scl_oe = 1'b0;
      wait (scl_w === 1'b1); // a stretched clock is waited out
      #40 r = sda_w;
      #40 scl_oe = 1'b1;
   endtask
   task automatic m_start;
      sda_oe = 1'b1;
      #80 scl_oe = 1'b1;
   endtask
   task automatic m_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin m_bit(d[i]); sh[i] = r; end
      m_bit(1'b1);
      ack = !r;
   endtask
   task automatic m_stop;
      #40 sda_oe = 1'b1;
      #40 scl_oe = 1'b0;
      wait (scl_w === 1'b1);
      #80 sda_oe = 1'b0;
      #80;
   endtask
endmodule // smbus_far_end
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the smbus byte engine against a far-end model.
// assumes the engine, its header, the checker and the far-end model compile first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int QC = 4;               // short quarter bit keeps the run brief
   logic       ref_clk, sys_rst;        // clock and reset
   logic [7:0] sfr_addr, sfr_wdata;     // register port drive
   logic       sfr_wr, sfr_rd;
   wire  [7:0] sfr_rdata;
   wire        byte_event_irq, scl_o, scl_oe, sda_o, sda_oe, p_scl_oe, p_sda_oe;
   wire        scl_w = ~(scl_oe | p_scl_oe); // pull-ups on both wires
   wire        sda_w = ~(sda_oe | p_sda_oe);
   int         n_errors, comparisons;
   logic [7:0] st;                      // last value read
   logic       a1, a2;                  // acks seen by the far master
   smbus_transfer_mode_engine #(.QUARTER_CYC(QC)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .byte_event_irq(byte_event_irq), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe));
   smbus_far_end far (.scl_w(scl_w), .sda_w(sda_w), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk); #2 sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
      @(posedge ref_clk); #2 sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk); #2 sfr_addr = a; sfr_rd = 1'b1;
      @(posedge ref_clk); #2 sfr_rd = 1'b0; d = sfr_rdata;
   endtask
   // bounded wait; the first edge lets a preceding clear land
   task automatic wait_irq;
      int n;
      n = 0;
      @(posedge ref_clk); #2;
      while (byte_event_irq !== 1'b1 && n < 20000) begin @(posedge ref_clk); #2; n++; end
      chk({7'h0, byte_event_irq}, 8'h01);
   endtask
   task automatic t_reset;
      rd(8'hc2, st); chk(st, 8'h00);
      rd(8'hc0, st); chk(st, 8'h00);
      rd(8'hc5, st); chk(st, 8'h00);
      wr(8'hc1, 8'h80);
      $display("test reset done");
   endtask
   task automatic t_mwrite;
      wr(8'hc0, 8'h20); wait_irq;
      rd(8'hc0, st); chk(st & 8'hf0, 8'he0);
      wr(8'hc2, 8'ha4); wr(8'hc0, 8'h00); wait_irq;
      chk(far.rx_last, 8'ha4);
      rd(8'hc0, st); chk(st & 8'hf2, 8'hc2);
      wr(8'hc2, 8'h96); wr(8'hc0, 8'h00); repeat (2) @(posedge ref_clk);
      wr(8'hc2, 8'h11); wait_irq; // write while shifting is dropped
      chk(far.rx_last, 8'h96);
      rd(8'hc2, st); chk(st, 8'h96);
      wr(8'hc0, 8'h10); repeat (8 * QC) @(posedge ref_clk);
      rd(8'hc0, st); chk(st & 8'hf1, 8'h00);
      $display("test master write done");
   endtask
   task automatic t_mread;
      far.tx_byte = 8'h5a;
      wr(8'hc0, 8'h20); wait_irq;
      wr(8'hc2, 8'ha5); wr(8'hc0, 8'h00); wait_irq;
      chk(far.rx_last, 8'ha5);
      wr(8'hc0, 8'h00); wait_irq; // no data written: turn to receiving
      rd(8'hc0, st); chk(st & 8'hf8, 8'h88);
      rd(8'hc2, st); chk(st, 8'h5a);
      wr(8'hc0, 8'h02); wait_irq;
      chk({7'h0, far.ack_seen}, 8'h01);
      wr(8'hc0, 8'h10); repeat (16 * QC) @(posedge ref_clk);
      chk({7'h0, far.ack_seen}, 8'h00);
      rd(8'hc0, st); chk(st & 8'hf1, 8'h00);
      $display("test master read done");
   endtask
   task automatic t_slave;
      far.slv_on = 1'b0;
      fork
         begin far.m_start(); far.m_byte(8'h42, a1); far.m_byte(8'hc3, a2); far.m_stop(); end
         begin
            wait_irq; rd(8'hc0, st); chk(st & 8'hc8, 8'h08);
            rd(8'hc2, st); chk(st, 8'h42);
            wr(8'hc0, 8'h02); wait_irq;
            rd(8'hc2, st); chk(st, 8'hc3);
            wr(8'hc0, 8'h02); wait_irq;
            rd(8'hc0, st); chk(st & 8'hd0, 8'h10);
            wr(8'hc0, 8'h00);
         end
      join
      chk({6'h0, a1, a2}, 8'h03);
      $display("test slave receive done");
   endtask
   task automatic t_snack;
      fork
         begin far.m_start(); far.m_byte(8'h42, a1); far.m_byte(8'h77, a2); far.m_stop(); end
         begin wait_irq; wr(8'hc0, 8'h00); end
      join
      repeat (8) @(posedge ref_clk);
      chk({6'h0, a1, byte_event_irq}, 8'h00);
      $display("test slave nack done");
   endtask
   // far master reads one byte; the engine sends it and stalls after the nack
   task automatic t_sread;
      fork
         begin far.m_start(); far.m_byte(8'h43, a1); far.m_byte(8'hff, a2); far.m_stop(); end
         begin
            wait_irq; rd(8'hc2, st); chk(st, 8'h43);
            wr(8'hc2, 8'ha7); wr(8'hc0, 8'h02); wait_irq;
            rd(8'hc0, st); chk(st & 8'hf2, 8'h40);
            wr(8'hc0, 8'h00); wait_irq;
            rd(8'hc0, st); chk(st & 8'hd0, 8'h10);
            wr(8'hc0, 8'h00);
         end
      join
      chk(far.sh, 8'ha7);
      chk({6'h0, a1, a2}, 8'h02);
      $display("test slave read done");
   endtask
   task automatic stop_test;
      $display("comparisons=%0d errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      n_errors = 0;
      comparisons = 0;
      repeat (5) @(posedge ref_clk);
      #2 sys_rst = 1'b0;
      t_reset;
      t_mwrite;
      t_mread;
      t_slave;
      t_snack;
      t_sread;
      stop_test;
   end
   // watchdog: the tests need well under a tenth of this span
   initial begin
      #800000;
      n_errors++;
      $display("watchdog expired");
      stop_test;
   end
endmodule // testbench
`default_nettype wire
